// ---- rtl/psc_pkg.sv ----
// shared constants and types for the pll and pwm channel-one control block
package psc_pkg;

  // ----------------------------------------------------------------
  // register map (indices; byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_PLL_PREDIV_MULT = 8'h88;
  localparam logic [7:0] IDX_PLL_OUT_DIV     = 8'h89;
  localparam logic [7:0] IDX_PWM_CH1_CTRL    = 8'h8a;
  localparam logic [7:0] IDX_PLL_STATUS      = 8'hfe;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PREDIV_BIT    = 7;
  localparam int MULT_LSB      = 0;
  localparam int MULT_W        = 5;
  localparam int OUTDIV_LSB    = 0;
  localparam int OUTDIV_W      = 3;
  localparam int PWM_EN_BIT    = 7;
  localparam int PWM_IDLE_BIT  = 6;
  localparam int PWM_FSEL_BIT  = 4;
  localparam int PWM_DIV_LSB   = 0;
  localparam int PWM_DIV_W     = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_REJ_BIT  = 1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic              RST_PREDIV = 1'b0;
  localparam logic [MULT_W-1:0] RST_MULT   = 5'h07;
  localparam logic [OUTDIV_W-1:0] RST_OUTDIV = 3'h3;
  localparam logic [7:0]        RST_PWM_CTRL = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int MCLK_MHZ     = 100;
  localparam int LOCK_TIME_US = 100;
  localparam int LOCK_CYCLES  = LOCK_TIME_US * MCLK_MHZ;
  localparam int OSC_DIV_EXP  = 3;   // osc / 8 toggles give osc / 16

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              prediv_sel;
    logic [MULT_W-1:0] feedback_mult;
    logic [OUTDIV_W-1:0] out_div_exp;
  } psc_pll_cfg_t;

  typedef struct packed {
    logic                 enable;
    logic                 idle_level;
    logic                 func_sel;
    logic [PWM_DIV_W-1:0] clk_div;
  } psc_pwm_cfg_t;

  typedef enum logic [1:0] {
    PWM_SRC_IDLE = 2'b00,
    PWM_SRC_DUTY = 2'b01,
    PWM_SRC_OSC  = 2'b10
  } psc_pwm_src_t;

endpackage : psc_pkg

// ---- rtl/psc_pow2_div.sv ----
// tick divider by a selectable power of two
`timescale 1ns/1ns
module psc_pow2_div
  import psc_pkg::*;
#(
  parameter int SEL_W = 4
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             tick_in,
  input  wire logic [SEL_W-1:0] sel,
  output logic                  tick_out
);

  localparam int CNT_W = (1 << SEL_W) - 1;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  if (SEL_W < 1 || SEL_W > 5) begin : g_bad_w
    $error("psc_pow2_div: SEL_W out of range");
  end

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] mask;

  // low sel bits of the counter all ones marks every 2^sel-th tick
  assign mask = CNT_W'(({{CNT_W{1'b0}}, 1'b1} << sel) - 1'b1);

  // free running count of input ticks
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (tick_in) begin
      cnt <= cnt + 1'b1;
    end
  end

  // one output tick per 2^sel input ticks
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick_in && ((cnt | ~mask) == {CNT_W{1'b1}});
    end
  end

endmodule : psc_pow2_div

// ---- rtl/psc_lock_timer.sv ----
// pll settle timer, restarted by each pll write
`timescale 1ns/1ns
module psc_lock_timer
  import psc_pkg::*;
#(
  parameter int CYCLES = LOCK_CYCLES
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic restart,
  output logic      busy
);

  localparam int CNT_W = $clog2(CYCLES + 1);

  if (CYCLES < 1) begin : g_bad_cycles
    $error("psc_lock_timer: CYCLES must be at least 1");
  end

  logic [CNT_W-1:0] remain;

  // a new write restarts the full wait even if one is running
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      remain <= '0;
    end else if (restart) begin
      remain <= CNT_W'(CYCLES);
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end
  end

  assign busy = (remain != '0);

endmodule : psc_lock_timer

// ---- rtl/psc_pll_pwm_ctrl.sv ----
// pll system clock configuration and pwm channel-one output control
//
// Summary of operation
// - Pre-divider bit divides the oscillator by 1 when clear, by 2 when set; reset 0.
// - Five-bit feedback multiplier resets to 07h; only values 1 to 31 are taken.
// - Three-bit output divider divides by two to its value, 1 up to 128; reset 03h.
// - With all pll fields at reset the system clock equals the oscillator.
// - System clock is oscillator times (mult+1) over (prediv+1) times two to the out divider.
// - The enable bit runs the pulse output; when clear the pin sits at the idle level, reset 0.
// - The idle-level bit gives low or high while disabled or asleep, only with function-select 0.
// - With function-select set the pin carries the oscillator divided by 16.
// - The four-bit clock divider feeds the pwm from system clock over two to its value.
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ns
module psc_pll_pwm_ctrl
  import psc_pkg::*;
#(
  parameter int LOCK_WAIT_CYCLES = LOCK_CYCLES,
  parameter int DUTY_W           = 8
) (
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  // avalon-mm slave, byte address
  input  wire logic [9:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  // clock sources as one-cycle ticks
  input  wire logic                 core_clk_tick,
  input  wire logic                 osc_tick,
  input  wire logic                 sleep,
  input  wire logic [DUTY_W-1:0]    pwm_duty,
  // to the analog pll core
  output psc_pll_cfg_t              pll_cfg,
  output logic [MULT_W:0]           core_clk_ratio_num,
  output logic [OUTDIV_W:0]         core_clk_ratio_den_log2,
  output logic                      pll_lock_wait,
  // pin
  output logic                      pwm_ch1_out
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (DUTY_W != 8) begin : g_bad_duty
    $error("psc_pll_pwm_ctrl: duty width must be 8");
  end
  if (LOCK_WAIT_CYCLES < 1) begin : g_bad_lock
    $error("psc_pll_pwm_ctrl: lock wait must be at least one cycle");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // word index of a byte address; misaligned maps to unused index 0
  function automatic logic [7:0] word_index(input logic [9:0] addr);
    if (addr[1:0] != 2'b00) begin
      return 8'h00;
    end
    return addr[9:2];
  endfunction : word_index

  function automatic logic is_mapped(input logic [7:0] idx);
    return (idx == IDX_PLL_PREDIV_MULT) || (idx == IDX_PLL_OUT_DIV) ||
           (idx == IDX_PWM_CH1_CTRL) || (idx == IDX_PLL_STATUS);
  endfunction : is_mapped

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  logic       bus_ack;
  logic       bus_req;
  logic [7:0] bus_idx;
  logic       wr_fire;
  logic [7:0] wr_byte;

  assign bus_req         = avs_read || avs_write;
  assign bus_idx         = word_index(avs_address);
  // one wait cycle, then the request completes on the next edge
  assign avs_waitrequest = bus_req && !bus_ack;
  assign wr_fire         = avs_write && bus_ack && avs_byteenable[0];
  assign wr_byte         = avs_writedata[7:0];

  // ack is high in the completing cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= bus_req && !bus_ack;
    end
  end

  // ----------------------------------------------------------------
  // pll configuration registers
  // ----------------------------------------------------------------
  logic prediv_sel;
  logic [MULT_W-1:0] feedback_mult;
  logic [OUTDIV_W-1:0] out_div_exp;
  logic mult_rejected;
  logic pll_write;

  // pre-divider and multiplier share one byte
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prediv_sel    <= RST_PREDIV;
      feedback_mult <= RST_MULT;
    end else if (wr_fire && bus_idx == IDX_PLL_PREDIV_MULT) begin
      prediv_sel <= wr_byte[PREDIV_BIT];
      // zero would stall the vco, so the old multiplier is kept
      if (wr_byte[MULT_LSB +: MULT_W] != '0) begin
        feedback_mult <= wr_byte[MULT_LSB +: MULT_W];
      end
    end
  end

  // records whether the latest multiplier write was refused
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mult_rejected <= 1'b0;
    end else if (wr_fire && bus_idx == IDX_PLL_PREDIV_MULT) begin
      mult_rejected <= (wr_byte[MULT_LSB +: MULT_W] == '0);
    end
  end

  // output divider exponent
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_div_exp <= RST_OUTDIV;
    end else if (wr_fire && bus_idx == IDX_PLL_OUT_DIV) begin
      out_div_exp <= wr_byte[OUTDIV_LSB +: OUTDIV_W];
    end
  end

  assign pll_write = wr_fire &&
                     (bus_idx == IDX_PLL_PREDIV_MULT || bus_idx == IDX_PLL_OUT_DIV);

  // ----------------------------------------------------------------
  // pll settle wait
  // ----------------------------------------------------------------
  // software still owns the wait; this only reports it in status
  psc_lock_timer #(
    .CYCLES (LOCK_WAIT_CYCLES)
  ) u_lock (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .restart (pll_write),
    .busy    (pll_lock_wait)
  );

  // ----------------------------------------------------------------
  // pll outputs and frequency ratio
  // ----------------------------------------------------------------
  // core_clk = osc * num / 2^den_log2; reset gives 8 / 2^3, i.e. osc
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pll_cfg                 <= '{RST_PREDIV, RST_MULT, RST_OUTDIV};
      core_clk_ratio_num      <= (MULT_W+1)'(RST_MULT) + 1'b1;
      core_clk_ratio_den_log2 <= (OUTDIV_W+1)'(RST_OUTDIV);
    end else begin
      pll_cfg <= '{prediv_sel, feedback_mult, out_div_exp};
      core_clk_ratio_num      <= (MULT_W+1)'(feedback_mult) + 1'b1;
      // prediv of 2 adds one to the power-of-two denominator
      core_clk_ratio_den_log2 <= (OUTDIV_W+1)'(out_div_exp) +
                                 (OUTDIV_W+1)'(prediv_sel);
    end
  end

  // ----------------------------------------------------------------
  // pwm channel-one control register
  // ----------------------------------------------------------------
  psc_pwm_cfg_t pwm_cfg;

  // reserved bit 5 is never stored
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_cfg <= '{RST_PWM_CTRL[PWM_EN_BIT], RST_PWM_CTRL[PWM_IDLE_BIT],
                   RST_PWM_CTRL[PWM_FSEL_BIT],
                   RST_PWM_CTRL[PWM_DIV_LSB +: PWM_DIV_W]};
    end else if (wr_fire && bus_idx == IDX_PWM_CH1_CTRL) begin
      pwm_cfg.enable     <= wr_byte[PWM_EN_BIT];
      pwm_cfg.idle_level <= wr_byte[PWM_IDLE_BIT];
      pwm_cfg.func_sel   <= wr_byte[PWM_FSEL_BIT];
      pwm_cfg.clk_div    <= wr_byte[PWM_DIV_LSB +: PWM_DIV_W];
    end
  end

  // ----------------------------------------------------------------
  // register read back
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;

  // unlisted and reserved bits are built as zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (bus_idx)
      IDX_PLL_PREDIV_MULT: begin
        rd_byte[PREDIV_BIT]             = prediv_sel;
        rd_byte[MULT_LSB +: MULT_W]     = feedback_mult;
      end
      IDX_PLL_OUT_DIV: begin
        rd_byte[OUTDIV_LSB +: OUTDIV_W] = out_div_exp;
      end
      IDX_PWM_CH1_CTRL: begin
        rd_byte[PWM_EN_BIT]              = pwm_cfg.enable;
        rd_byte[PWM_IDLE_BIT]            = pwm_cfg.idle_level;
        rd_byte[PWM_FSEL_BIT]            = pwm_cfg.func_sel;
        rd_byte[PWM_DIV_LSB +: PWM_DIV_W] = pwm_cfg.clk_div;
      end
      IDX_PLL_STATUS: begin
        rd_byte[STAT_BUSY_BIT] = pll_lock_wait;
        rd_byte[STAT_REJ_BIT]  = mult_rejected;
      end
      default: ;
    endcase
  end

  // data is captured in the wait cycle and held through completion
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !bus_ack) begin
      avs_readdata <= is_mapped(bus_idx) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // pwm source clock divider
  // ----------------------------------------------------------------
  logic pwm_src_tick;

  psc_pow2_div #(
    .SEL_W (PWM_DIV_W)
  ) u_src_div (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .tick_in  (core_clk_tick),
    .sel      (pwm_cfg.clk_div),
    .tick_out (pwm_src_tick)
  );

  // ----------------------------------------------------------------
  // duty waveform
  // ----------------------------------------------------------------
  logic [DUTY_W-1:0] duty_cnt;
  logic              duty_level;

  // 256 source ticks per period; duty n gives n+1 high ticks
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      duty_cnt <= '0;
    end else if (!pwm_cfg.enable) begin
      duty_cnt <= '0;                                        // restart on enable
    end else if (pwm_src_tick) begin
      duty_cnt <= duty_cnt + 1'b1;
    end
  end

  assign duty_level = (duty_cnt <= pwm_duty);

  // ----------------------------------------------------------------
  // fixed oscillator / 16 waveform
  // ----------------------------------------------------------------
  logic osc8_tick;
  logic osc16_level;

  psc_pow2_div #(
    .SEL_W (2)
  ) u_osc_div (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .tick_in  (osc_tick),
    .sel      (2'(OSC_DIV_EXP)),
    .tick_out (osc8_tick)
  );

  // toggling every 8 oscillator periods makes a 16-period square wave
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      osc16_level <= 1'b0;
    end else if (osc8_tick) begin
      osc16_level <= ~osc16_level;
    end
  end

  // ----------------------------------------------------------------
  // pin source selection
  // ----------------------------------------------------------------
  psc_pwm_src_t pin_src;

  // function-select wins over enable, idle level and sleep
  always_comb begin
    if (pwm_cfg.func_sel) begin
      pin_src = PWM_SRC_OSC;
    end else if (pwm_cfg.enable && !sleep) begin
      pin_src = PWM_SRC_DUTY;
    end else begin
      pin_src = PWM_SRC_IDLE;
    end
  end

  // registered pin keeps glitches from the selector off the board
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_ch1_out <= 1'b0;
    end else begin
      unique case (pin_src)
        PWM_SRC_OSC:  pwm_ch1_out <= osc16_level;
        PWM_SRC_DUTY: pwm_ch1_out <= duty_level;
        PWM_SRC_IDLE: pwm_ch1_out <= pwm_cfg.idle_level;
        default:      pwm_ch1_out <= 1'b0;
      endcase
    end
  end

endmodule : psc_pll_pwm_ctrl

// ---- verif/psc_clk_src_model.sv ----
// oscillator and system clock tick sources outside the block
`timescale 1ns/1ns
module psc_clk_src_model #(
  parameter int OSC_PER  = 5,
  parameter int CORE_PER = 2
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  output logic      osc_tick,
  output logic      core_clk_tick
);
  int osc_cnt;
  int core_cnt;

  // ----------------------------------------------------------------
  // free running sources
  // ----------------------------------------------------------------
  // a crystal never stops, so ticks run from reset release on
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt  <= 0;
      core_cnt <= 0;
    end else begin
      osc_cnt  <= (osc_cnt == OSC_PER - 1) ? 0 : osc_cnt + 1;
      core_cnt <= (core_cnt == CORE_PER - 1) ? 0 : core_cnt + 1;
    end
  end
  assign osc_tick      = (osc_cnt == OSC_PER - 1);
  assign core_clk_tick = (core_cnt == CORE_PER - 1);
endmodule : psc_clk_src_model

// ---- verif/psc_pll_pwm_ctrl_assertions.sv ----
// concurrent checks on the control block's ports
`timescale 1ns/1ns
module psc_pll_pwm_ctrl_assertions
  import psc_pkg::*;
#(
  parameter int LOCK_WAIT_CYCLES = LOCK_CYCLES,
  parameter int DUTY_W           = 8
) (
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic [9:0]        avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic              core_clk_tick,
  input wire logic              osc_tick,
  input wire logic              sleep,
  input wire logic [DUTY_W-1:0] pwm_duty,
  input wire psc_pll_cfg_t      pll_cfg,
  input wire logic [MULT_W:0]   core_clk_ratio_num,
  input wire logic [OUTDIV_W:0] core_clk_ratio_den_log2,
  input wire logic              pll_lock_wait,
  input wire logic              pwm_ch1_out
);
  logic [7:0] pwm_shadow;
  logic [3:0] hold;
  logic       pwm_wr;
  logic       idle_cond;
  logic       full_cond;
  logic [7:0] rsv_mask;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // shadow of the channel-one control byte
  // ----------------------------------------------------------------
  assign pwm_wr = avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == 10'h228;
  // hold saturates so the pin checks wait out the selection latency
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_shadow <= 8'h00;
      hold       <= 4'h0;
    end else if (pwm_wr) begin
      pwm_shadow <= avs_writedata[7:0] & 8'hdf;
      hold       <= 4'h0;
    end else if (hold != 4'hf) begin
      hold <= hold + 4'h1;
    end
  end
  assign idle_cond = !pwm_shadow[4] && (!pwm_shadow[7] || sleep) && hold == 4'hf;
  assign full_cond = pwm_shadow[7] && !pwm_shadow[4] && !sleep && (&pwm_duty) && hold == 4'hf;
  // bits that must read zero at each address
  assign rsv_mask = (avs_address == 10'h220) ? 8'h60 : (avs_address == 10'h224) ? 8'hf8 :
                    (avs_address == 10'h228) ? 8'h20 : (avs_address == 10'h3f8) ? 8'hfc : 8'hff;

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence s_req_start;
    $rose(avs_read || avs_write);
  endsequence
  sequence s_read_done;
    avs_read && !avs_waitrequest;
  endsequence
  sequence s_pll_write;
    avs_write && !avs_waitrequest && avs_byteenable[0] &&
      ((avs_address == 10'h220 && avs_writedata[4:0] != 5'h00) || avs_address == 10'h224);
  endsequence

  a_one_wait: assert property (s_req_start |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("wait not one cycle");
  a_mult_legal: assert property (pll_cfg.feedback_mult != 5'h00)
    else $error("multiplier zero");
  a_ratio_num: assert property (core_clk_ratio_num == {1'b0, pll_cfg.feedback_mult} + 6'h01)
    else $error("ratio numerator wrong");
  a_ratio_den: assert property (core_clk_ratio_den_log2 ==
    {1'b0, pll_cfg.out_div_exp} + {3'h0, pll_cfg.prediv_sel})
    else $error("ratio denominator wrong");
  a_reset_unity: assert property (pll_cfg == 9'h03b |->
    core_clk_ratio_num == 6'h08 && core_clk_ratio_den_log2 == 4'h3)
    else $error("reset ratio is not unity");
  a_lock_start: assert property (s_pll_write |=> pll_lock_wait [*8])
    else $error("lock wait not raised");
  a_upper_zero: assert property (s_read_done |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_reserved_zero: assert property (s_read_done |-> (avs_readdata[7:0] & rsv_mask) == 8'h00)
    else $error("reserved bits read nonzero");
  a_idle_level: assert property (idle_cond [*3] |-> pwm_ch1_out == pwm_shadow[6])
    else $error("pin not at idle level");
  a_full_duty: assert property (full_cond [*3] |-> pwm_ch1_out)
    else $error("full duty pin not high");
  a_osc_edge: assert property (pwm_shadow[4] && hold == 4'hf && $changed(pwm_ch1_out) |->
    $past(osc_tick, 2) || $past(osc_tick, 3))
    else $error("pin change without osc tick");
endmodule : psc_pll_pwm_ctrl_assertions

bind psc_pll_pwm_ctrl psc_pll_pwm_ctrl_assertions #(
  .LOCK_WAIT_CYCLES(LOCK_WAIT_CYCLES), .DUTY_W(DUTY_W)
) i_chk (
  .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .core_clk_tick(core_clk_tick), .osc_tick(osc_tick), .sleep(sleep), .pwm_duty(pwm_duty),
  .pll_cfg(pll_cfg), .core_clk_ratio_num(core_clk_ratio_num),
  .core_clk_ratio_den_log2(core_clk_ratio_den_log2), .pll_lock_wait(pll_lock_wait),
  .pwm_ch1_out(pwm_ch1_out)
);

// ---- verif/psc_pll_pwm_ctrl_tb_top.sv ----
// self-checking bench for the pll and pwm control block
`timescale 1ns/1ns
module psc_pll_pwm_ctrl_tb_top
  import psc_pkg::*;
;
  localparam int LOCK_W = 20;
  localparam int OSC_P  = 5;
  localparam int CORE_P = 2;

  logic         mclk;
  logic         rst_n;
  logic [9:0]   avs_address;
  logic         avs_read;
  logic         avs_write;
  logic [31:0]  avs_writedata;
  logic [3:0]   avs_byteenable;
  logic [31:0]  avs_readdata;
  logic         avs_waitrequest;
  logic         core_clk_tick;
  logic         osc_tick;
  logic         sleep;
  logic [7:0]   pwm_duty;
  psc_pll_cfg_t pll_cfg;
  logic [5:0]   core_clk_ratio_num;
  logic [3:0]   core_clk_ratio_den_log2;
  logic         pll_lock_wait;
  logic         pwm_ch1_out;
  int           mismatches;
  int           tests_run;
  int           mdl[3];
  logic [7:0]   mask[3] = '{8'h9f, 8'h07, 8'hdf};
  logic [31:0]  seed;
  logic [31:0]  rd;
  int           hi;
  int           per;

  psc_pll_pwm_ctrl #(.LOCK_WAIT_CYCLES(LOCK_W), .DUTY_W(8)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .core_clk_tick(core_clk_tick), .osc_tick(osc_tick), .sleep(sleep), .pwm_duty(pwm_duty),
    .pll_cfg(pll_cfg), .core_clk_ratio_num(core_clk_ratio_num),
    .core_clk_ratio_den_log2(core_clk_ratio_den_log2), .pll_lock_wait(pll_lock_wait),
    .pwm_ch1_out(pwm_ch1_out)
  );
  psc_clk_src_model #(.OSC_PER(OSC_P), .CORE_PER(CORE_P)) i_src (
    .mclk(mclk), .rst_n(rst_n), .osc_tick(osc_tick), .core_clk_tick(core_clk_tick)
  );

  // ----------------------------------------------------------------
  // clock, helpers and bus tasks
  // ----------------------------------------------------------------
  always #5 mclk = ~mclk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic stop_test;
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
    int n;
    @(posedge mclk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= {24'h0, d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      mismatches++;
      stop_test();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  // a zero multiplier is refused but the pre-divider bit still lands
  task automatic wr_reg(input int i, input logic [7:0] d);
    if (i == 0 && d[4:0] == 5'h00) mdl[0] = {d[7], 2'b00, 5'(mdl[0])};
    else mdl[i] = d & mask[i];
    bus(1'b1, 10'(10'h220 + 4 * i), d);
  endtask : wr_reg

  task automatic rd_chk(input int i);
    bus(1'b0, 10'(10'h220 + 4 * i), 8'h00);
    check(rd, mdl[i]);
  endtask : rd_chk

  task automatic pll_chk(input logic lk);
    int m, p, k, n;
    m = mdl[0] & 31;
    p = mdl[0] >> 7;
    k = mdl[1] & 7;
    repeat (2) @(negedge mclk);
    check(pll_cfg, {p[0], m[4:0], k[2:0]});
    check(core_clk_ratio_num, m + 1);
    check(core_clk_ratio_den_log2, k + p);
    if (lk) check(pll_lock_wait, 1);
    n = 0;
    // software keeps off the system clock until settled
    while (pll_lock_wait !== 1'b0 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    check(n < 100, 1);
  endtask : pll_chk

  // high and period cycles from a clean rising edge
  task automatic measure;
    int n;
    n = 0;
    hi = 0;
    per = 0;
    for (int s = 0; s < 4; s++) begin
      while (pwm_ch1_out !== s[0] && n < 20000) begin
        @(negedge mclk);
        n++;
        hi += (s == 2);
        per += (s > 1);
      end
    end
    if (n >= 20000) begin
      mismatches++;
      stop_test();
    end
  endtask : measure

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0; rst_n = 1'b0; avs_address = 10'h0; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = 32'h0; avs_byteenable = 4'h1; sleep = 1'b0; pwm_duty = 8'h00;
    mismatches = 0; tests_run = 0; mdl = '{7, 3, 0}; seed = 32'hc5f772d6;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    check(core_clk_ratio_num >> core_clk_ratio_den_log2, 1);
    for (int i = 0; i < 3; i++) rd_chk(i);
    bus(1'b0, 10'h22c, 8'h00);
    check(rd, 0);
    for (int i = 0; i < 3; i++) begin
      wr_reg(i, 8'hff);
      if (i < 2) pll_chk(1'b1);
      rd_chk(i);
    end
    // multiplier kept at four or more so a 25 MHz crystal reaches 110 MHz
    for (int j = 0; j < 6; j++) begin
      seed = xs(seed);
      wr_reg(0, {seed[7], 2'b00, 5'(4 + seed[12:8] % 28)});
      pll_chk(1'b1);
      wr_reg(1, seed[23:16]);
      pll_chk(1'b1);
    end
    wr_reg(0, 8'h80);
    pll_chk(1'b0);
    rd_chk(0);
    bus(1'b0, 10'h3f8, 8'h00);
    check(rd, 2);
    avs_byteenable <= 4'h0;
    bus(1'b1, 10'h224, 8'h05);
    avs_byteenable <= 4'h1;
    rd_chk(1);
    // disabled and asleep-while-enabled, each with both idle levels
    for (int j = 0; j < 4; j++) begin
      wr_reg(2, {j[1], j[0], 6'h00});
      sleep    <= j[1];
      pwm_duty <= 8'hff;
      repeat (4) @(negedge mclk);
      check(pwm_ch1_out, j[0]);
    end
    wr_reg(2, 8'h80);
    sleep <= 1'b0;
    repeat (4) @(negedge mclk);
    check(pwm_ch1_out, 1);
    for (int dv = 0; dv < 2; dv++) begin
      wr_reg(2, 8'(8'h80 | dv));
      pwm_duty <= 8'h03;
      measure();
      check(hi, 4 * (1 << dv) * CORE_P);
      check(per, 256 * (1 << dv) * CORE_P);
    end
    wr_reg(2, 8'h50);
    sleep <= 1'b1;
    measure();
    check(hi, 8 * OSC_P);
    check(per, 16 * OSC_P);
    stop_test();
  end
endmodule : psc_pll_pwm_ctrl_tb_top
